// file: core/io_decode_pkg.sv
// Constants and carrier types for the I/O space chip-select decoder
package io_decode_pkg;

  // ----------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------
  localparam logic [31:0] main_io_base = 32'h0300_0000;
  localparam logic [31:0] main_io_last = 32'h03ff_ffff;
  localparam logic [31:0] ext_io_base = 32'h0800_0000;
  localparam logic [31:0] ext_io_last = 32'h0fff_ffff;
  localparam logic [31:0] ext_io_narrow_last = 32'h08ff_ffff;
  localparam logic [31:0] module_a_base = 32'h0300_0000;
  localparam logic [31:0] module_a_last = 32'h0300_ffff;
  localparam logic [31:0] module_a_narrow_last = 32'h0300_3fff;
  localparam logic [31:0] combo_cs_base = 32'h0301_0000;
  localparam logic [31:0] combo_dack_base = 32'h0301_2000;
  localparam logic [31:0] combo_term_base = 32'h0302_a000;
  localparam logic [31:0] card_second_base = 32'h0302_b000;
  localparam logic [31:0] card_first_base = 32'h0302_b800;
  localparam logic [31:0] reserved_a_base = 32'h0302_c000;
  localparam logic [31:0] module_b_base = 32'h0303_0000;
  localparam logic [31:0] module_b_last = 32'h0303_ffff;
  localparam logic [31:0] module_b_narrow_last = 32'h0303_3fff;
  localparam logic [31:0] reserved_b_base = 32'h0304_0000;
  localparam logic [31:0] internal_regs_base = 32'h0320_0000;
  localparam logic [31:0] simple_io_base = 32'h0321_0000;
  localparam logic [31:0] video_regs_base = 32'h0340_0000;
  localparam logic [31:0] reserved_c_base = 32'h0350_0000;

  // Second simple select: bits [23:16] of the four windows, and width of match
  localparam logic [7:0] sio2_win0 = 8'h24;
  localparam logic [7:0] sio2_win1 = 8'h2c;
  localparam logic [7:0] sio2_win2 = 8'h34;
  localparam logic [7:0] sio2_win3 = 8'h3c;
  localparam logic [15:0] sio2_narrow_mask = 16'hc000; // 16K window inside 64K

  // Simple cycle speed field in the address
  localparam int sio_speed_hi = 20;
  localparam int sio_speed_lo = 19;

  // Simple cycle lengths in 8 MHz ticks, by speed code
  localparam logic [3:0] sio_len_slow = 4'h7;
  localparam logic [3:0] sio_len_medium = 4'h6;
  localparam logic [3:0] sio_len_fast = 4'h5;
  localparam logic [3:0] sio_len_sync = 4'h5;
  // PC-style cycle length in 16 MHz ticks, and module handshake timeout none
  localparam logic [3:0] pc_len = 4'h4;

  // Tick dividers from 125 MHz (rounded down: 62.5 ns -> 7, 125 ns -> 15 cycles)
  localparam int clk_mhz = 125;
  localparam int pc_tick_mhz = 16;
  localparam int sio_tick_mhz = 8;
  localparam logic [4:0] pc_tick_div = 5'(clk_mhz / pc_tick_mhz);
  localparam logic [4:0] sio_tick_div = 5'(clk_mhz / sio_tick_mhz);

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum {
    kind_none,
    kind_internal,
    kind_module,
    kind_pc,
    kind_simple
  } cycle_kind_type;

  // Active-low chip selects and active-high terminal count, one word
  typedef struct packed {
    logic module_space_select_n;
    logic combo_chip_select_n;
    logic combo_dma_ack_n;
    logic terminal_count;
    logic card_select_first_n;
    logic card_select_second_n;
    logic simple_io_select_first_n;
    logic simple_io_select_second_n;
    logic extended_area_select_n;
  } select_bus_type;

  localparam select_bus_type selects_idle = '{
    module_space_select_n: 1'b1, combo_chip_select_n: 1'b1, combo_dma_ack_n: 1'b1,
    terminal_count: 1'b0, card_select_first_n: 1'b1, card_select_second_n: 1'b1,
    simple_io_select_first_n: 1'b1, simple_io_select_second_n: 1'b1,
    extended_area_select_n: 1'b1};

  // External width-extension buffer controls, active low
  typedef struct packed {
    logic write_buf_en_n;
    logic read_buf_en_n;
    logic latch_out_n;
  } widen_ctl_type;

  localparam widen_ctl_type widen_idle = '{write_buf_en_n: 1'b1, read_buf_en_n: 1'b1,
                                           latch_out_n: 1'b1};

endpackage

// file: core/sync_bit.sv
// Two flip-flop synchroniser for a level from another clock domain
`timescale 1ns/1ps
module sync_bit (
  input wire logic clk_sys, // System clock
  input wire logic rst, // Synchronous reset, high
  input wire logic async_in, // Level from outside
  output logic sync_out // Level safe to use
);
  logic stage_one;
  logic next_stage_one;
  logic next_sync_out;

  // First stage feeds only the second
  always_comb begin
    next_stage_one = async_in;
    next_sync_out = stage_one;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stage_one <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      stage_one <= next_stage_one;
      sync_out <= next_sync_out;
    end
  end
endmodule // sync_bit

// file: core/io_space_chip_select_decode.sv
// I/O space address decoder and I/O bus cycle sequencer
`timescale 1ns/1ps
// Summary of operation
// - Addresses 0x03000000..0x03FFFFFF form the main I/O space, decoded into sub-areas.
// - Extended space from 0x08000000 uses PC-style cycles only, eight 16 Mbyte areas.
// - An extended space access asserts the extended-area select; with narrow decode high only the first 16 Mbyte does.
// - Regions at 0x03000000 and 0x03030000 assert the module-space select.
// - Region at 0x03010000 runs PC-style cycles with the combo chip select.
// - Region at 0x03012000 runs PC-style cycles with combo DMA acknowledge instead.
// - Region at 0x0302A000 asserts combo DMA acknowledge and terminal count.
// - Region at 0x0302B000 runs PC-style cycles asserting the second card select.
// - Region at 0x0302B800 runs PC-style cycles asserting the first card select.
// - Region at 0x03200000 selects internal registers, no external bus cycle.
// - Region from 0x03210000 is simple I/O, asserting the simple selects.
// - Region at 0x03400000 selects internal video/sound registers, no external select.
// - A 16-bit I/O data bus runs independently of main bus DMA.
// - Three access types: PC-style 16 MHz, handshake 8 MHz, simple 8 MHz.
// - Synchronise at start of every I/O cycle and at end of all but module cycles; extra delay accepted.
// - Drive controls for external latches widening I/O with upper data half.
// - Narrow decode high limits module select to two 16 Kbyte windows.
// - Simple accesses assert the first simple select with the read or write strobe.
module io_space_chip_select_decode
  import io_decode_pkg::*;
(
  input wire logic clk_sys, // 125 MHz system clock
  input wire logic rst, // Synchronous reset, high
  input wire logic req_valid, // Access request from processor side
  input wire logic [31:0] req_addr, // Access byte address
  input wire logic req_write, // 1 write, 0 read
  input wire logic [31:0] req_wdata, // Write data, upper half goes out
  output logic req_done, // One-cycle pulse, access finished
  output logic [31:0] req_rdata, // Read data, lower half from I/O bus
  output logic req_internal, // Pulse: access is for internal registers
  input wire logic narrow_decode_input, // Narrow decode strap, from pin
  input wire logic io_ready, // Stretch input for PC-style cycles, pin
  input wire logic io_grant_n, // Module handshake grant, pin
  output logic io_request_n, // Module handshake request
  output logic io_read_strobe_n, // Read strobe
  output logic io_write_strobe_n, // Write strobe
  output logic io_read_not_write, // Direction during module cycles
  input wire logic [15:0] io_data_bus_in, // I/O data bus level
  output logic [15:0] io_data_bus_out, // I/O data bus drive value
  output logic io_data_bus_oe, // High while driving the I/O bus
  output select_bus_type selects, // Chip selects, active low; terminal count active high
  output widen_ctl_type widen_ctl // External widening buffer controls
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic narrow_s;
  logic ready_s;
  logic grant_n_s;
  wire logic [15:0] data_in_s;

  // Each pin waits two flops; strap and handshakes are slow levels, so the lag is harmless
  sync_bit u_sync_narrow (
    .clk_sys(clk_sys), // System clock
    .rst(rst), // Synchronous reset
    .async_in(narrow_decode_input), // Strap pin
    .sync_out(narrow_s) // Strap, usable
  );
  sync_bit u_sync_ready (
    .clk_sys(clk_sys), // System clock
    .rst(rst), // Synchronous reset
    .async_in(io_ready), // Stretch pin
    .sync_out(ready_s) // Stretch, usable
  );
  sync_bit u_sync_grant (
    .clk_sys(clk_sys), // System clock
    .rst(rst), // Synchronous reset
    .async_in(io_grant_n), // Grant pin
    .sync_out(grant_n_s) // Grant, usable
  );

  // Read data crosses bit by bit; the peripheral holds it through the strobe,
  // so every bit has settled long before the end of the cycle captures it
  for (genvar bit_idx = 0; bit_idx < $bits(io_data_bus_in); bit_idx++) begin : g_data_sync
    sync_bit u_sync_data (
      .clk_sys(clk_sys), // System clock
      .rst(rst), // Synchronous reset
      .async_in(io_data_bus_in[bit_idx]), // One bus bit
      .sync_out(data_in_s[bit_idx]) // Same bit, usable
    );
  end

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Decode of the address standing on the request lines
  cycle_kind_type dec_kind;
  select_bus_type dec_sel;
  logic [3:0] dec_len;
  logic in_range_a;
  logic in_range_b;

  // Pure function of address and narrow strap; one region wins per access.
  // Bases are tested from the top down, so each region ends where the next
  // one above it begins; only the extended space, the main space and the module regions also test an upper bound.
  always_comb begin
    dec_kind = kind_none;
    dec_sel = selects_idle;
    dec_len = pc_len;
    in_range_a = 1'b0;
    in_range_b = 1'b0;
    if (req_addr >= ext_io_base && req_addr <= ext_io_last) begin
      dec_kind = kind_pc;
      // The cycle runs over the whole space; the strap only narrows the select
      dec_sel.extended_area_select_n = narrow_s && (req_addr > ext_io_narrow_last);
    end else if (req_addr >= main_io_base && req_addr <= main_io_last) begin
      if (req_addr >= reserved_c_base) begin
        dec_kind = kind_none;
      end else if (req_addr >= video_regs_base) begin
        dec_kind = kind_internal;
      end else if (req_addr >= simple_io_base) begin
        dec_kind = kind_simple;
        dec_sel.simple_io_select_first_n = 1'b0;
        if (req_addr[23:16] == sio2_win0 || req_addr[23:16] == sio2_win1 ||
            req_addr[23:16] == sio2_win2 || req_addr[23:16] == sio2_win3) begin
          dec_sel.simple_io_select_second_n = narrow_s && ((req_addr[15:0] & sio2_narrow_mask) != 16'h0000);
        end
        // Two address bits pick one of four speed codes; fast and sync share one length, so three lengths
        case (req_addr[sio_speed_hi:sio_speed_lo])
          2'b00: dec_len = sio_len_slow;
          2'b01: dec_len = sio_len_medium;
          2'b10: dec_len = sio_len_fast;
          default: dec_len = sio_len_sync;
        endcase
      end else if (req_addr >= internal_regs_base) begin
        dec_kind = kind_internal;
      end else if (req_addr >= reserved_b_base) begin
        dec_kind = kind_none;
      end else if (req_addr >= module_b_base) begin
        // Outside the narrow window the access runs no cycle at all
        in_range_b = req_addr <= (narrow_s ? module_b_narrow_last : module_b_last);
        dec_kind = in_range_b ? kind_module : kind_none;
        dec_sel.module_space_select_n = !in_range_b;
      end else if (req_addr >= reserved_a_base) begin
        dec_kind = kind_none;
      end else if (req_addr >= card_first_base) begin
        dec_kind = kind_pc;
        dec_sel.card_select_first_n = 1'b0;
      end else if (req_addr >= card_second_base) begin
        dec_kind = kind_pc;
        dec_sel.card_select_second_n = 1'b0;
      end else if (req_addr >= combo_term_base) begin
        dec_kind = kind_pc;
        dec_sel.combo_dma_ack_n = 1'b0;
        dec_sel.terminal_count = 1'b1;
      end else if (req_addr >= combo_dack_base) begin
        dec_kind = kind_pc;
        dec_sel.combo_dma_ack_n = 1'b0;
      end else if (req_addr >= combo_cs_base) begin
        dec_kind = kind_pc;
        dec_sel.combo_chip_select_n = 1'b0;
      end else begin
        in_range_a = req_addr <= (narrow_s ? module_a_narrow_last : module_a_last);
        dec_kind = in_range_a ? kind_module : kind_none;
        dec_sel.module_space_select_n = !in_range_a;
      end
    end
  end

  // ----------------------------------------------------------------
  // I/O clock ticks, free running from the system clock
  // ----------------------------------------------------------------
  logic [4:0] pc_div;
  logic [4:0] sio_div;
  logic [4:0] next_pc_div;
  logic [4:0] next_sio_div;
  logic pc_tick;
  logic sio_tick;

  // Cycles start only on a tick, so phase costs up to one tick period
  // Dividers round down, so ticks run slightly fast; the extra end tick keeps the margin
  always_comb begin
    pc_tick = (pc_div == 5'h00);
    sio_tick = (sio_div == 5'h00);
    next_pc_div = pc_tick ? pc_tick_div - 5'h01 : pc_div - 5'h01;
    next_sio_div = sio_tick ? sio_tick_div - 5'h01 : sio_div - 5'h01;
  end

  // Zero out of reset makes the first cycle after release a tick
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pc_div <= 5'h00;
      sio_div <= 5'h00;
    end else begin
      pc_div <= next_pc_div;
      sio_div <= next_sio_div;
    end
  end

  // ----------------------------------------------------------------
  // Cycle sequencer
  // ----------------------------------------------------------------
  // Start and, except in module cycles, end each wait for an I/O clock tick: that is the synchronisation
  typedef enum {
    st_idle,
    st_start_sync,
    st_active,
    st_end_sync,
    st_done
  } seq_state_type;

  seq_state_type state;
  seq_state_type next_state;
  cycle_kind_type kind;
  cycle_kind_type next_kind;
  select_bus_type cur_sel;
  select_bus_type next_cur_sel;
  logic [3:0] len_left;
  logic [3:0] next_len_left;
  logic is_write;
  logic next_is_write;
  logic [31:0] wdata;
  logic [31:0] next_wdata;
  logic [31:0] next_req_rdata;
  logic step_tick;

  // Tick of the clock that times the current cycle kind
  assign step_tick = (kind == kind_pc) ? pc_tick : sio_tick;

  // Next values of the sequencer; defaults hold every register
  always_comb begin
    next_state = state;
    next_kind = kind;
    next_cur_sel = cur_sel;
    next_len_left = len_left;
    next_is_write = is_write;
    next_wdata = wdata;
    next_req_rdata = req_rdata;
    case (state)
      st_idle: begin
        if (req_valid) begin
          next_kind = dec_kind;
          next_cur_sel = selects_idle;
          next_len_left = dec_len;
          next_is_write = req_write;
          next_wdata = req_wdata;
          // Internal and unmapped accesses never touch the I/O bus
          next_state = (dec_kind == kind_internal || dec_kind == kind_none) ? st_done : st_start_sync;
          if (dec_kind != kind_internal && dec_kind != kind_none) begin
            next_cur_sel = dec_sel;
          end
        end
      end
      st_start_sync: begin
        // Bus stays quiet until the I/O clock ticks
        if (step_tick) begin
          next_state = st_active;
        end
      end
      st_active: begin
        // Module cycles wait for grant; others count ticks, PC also waits for ready
        if (kind == kind_module) begin
          if (!grant_n_s) begin
            next_state = st_end_sync;
          end
        end else if (step_tick) begin
          if (len_left > 4'h1) begin
            next_len_left = len_left - 4'h1;
          end else if (kind != kind_pc || ready_s) begin
            next_state = st_end_sync;
          end
        end
      end
      st_end_sync: begin
        // Data sampled here, selects released on the next tick, or at once for module cycles;
        // the synced bits lag two cycles, well inside the strobe
        next_req_rdata = {16'h0000, data_in_s};
        if (step_tick || kind == kind_module) begin
          next_state = st_done;
          next_cur_sel = selects_idle;
        end
      end
      st_done: begin
        // One cycle of done; the next request is taken after it
        next_state = st_idle;
        next_cur_sel = selects_idle;
      end
      default: begin
        next_state = st_idle;
        next_cur_sel = selects_idle;
      end
    endcase
  end

  // Registers only
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state <= st_idle;
      kind <= kind_none;
      cur_sel <= selects_idle;
      len_left <= 4'h0;
      is_write <= 1'b0;
      wdata <= 32'h0000_0000;
      req_rdata <= 32'h0000_0000;
    end else begin
      state <= next_state;
      kind <= next_kind;
      cur_sel <= next_cur_sel;
      len_left <= next_len_left;
      is_write <= next_is_write;
      wdata <= next_wdata;
      req_rdata <= next_req_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  logic bus_phase;

  // Selects held across the whole external cycle, one region only
  assign bus_phase = (state == st_active) || (state == st_end_sync);
  assign selects = cur_sel;
  assign req_done = (state == st_done);
  assign req_internal = (state == st_done) && (kind == kind_internal);

  // Handshake request for module cycles, and the direction line
  assign io_request_n = !((kind == kind_module) && bus_phase);
  assign io_read_not_write = !is_write;

  // Module cycles use no strobes; the others strobe only while on the bus
  assign io_read_strobe_n = !(bus_phase && !is_write && kind != kind_module);
  assign io_write_strobe_n = !(bus_phase && is_write && kind != kind_module);

  // Upper half of the write word goes out on the I/O bus
  assign io_data_bus_out = wdata[31:16];
  assign io_data_bus_oe = bus_phase && is_write;

  // Width extension buffers used only on PC-style cycles
  // The latch closes in the last phase of a read so the upper half is held
  always_comb begin
    widen_ctl = widen_idle;
    if (bus_phase && kind == kind_pc) begin
      widen_ctl.write_buf_en_n = !is_write;
      widen_ctl.read_buf_en_n = is_write;
      widen_ctl.latch_out_n = !(state == st_end_sync && !is_write);
    end
  end
endmodule // io_space_chip_select_decode

// file: bench/io_decode_checker.sv
// Assertion checker for the I/O chip-select decoder
`timescale 1ns/1ps
module io_decode_checker
  import io_decode_pkg::*;
(
  input wire logic clk_sys, // System clock
  input wire logic rst, // Sync reset
  input wire logic req_done, // Access finished
  input wire logic req_internal, // Internal hit
  input wire logic io_grant_n, // Handshake grant
  input wire logic io_request_n, // Handshake request
  input wire logic io_read_strobe_n, // Read strobe
  input wire logic io_write_strobe_n, // Write strobe
  input wire logic io_data_bus_oe, // Bus drive enable
  input wire select_bus_type selects, // Chip selects
  input wire widen_ctl_type widen_ctl // Widening controls
);
  wire strobe_any = !io_read_strobe_n || !io_write_strobe_n;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ----
  // Select relations
  // ----
  a_one_region: assert property ($onehot0(~{selects.module_space_select_n, selects.combo_chip_select_n,
    selects.combo_dma_ack_n, selects.card_select_first_n, selects.card_select_second_n,
    selects.simple_io_select_first_n, selects.extended_area_select_n})) else $error("two regions selected");
  a_count_with_ack: assert property (selects.terminal_count |-> !selects.combo_dma_ack_n)
    else $error("terminal count without ack");
  a_sio_pair: assert property (!selects.simple_io_select_second_n |-> !selects.simple_io_select_first_n)
    else $error("second simple select alone");
  a_module_no_strobe: assert property (!selects.module_space_select_n |-> !strobe_any)
    else $error("strobe in module cycle");
  a_idle_after_done: assert property (req_done |=> selects == selects_idle)
    else $error("selects held after done");
  a_done_pulse: assert property (req_done |=> !req_done) else $error("done longer than one cycle");
  a_internal_quiet: assert property (req_internal |-> selects == selects_idle && io_request_n && !strobe_any)
    else $error("internal access drove the bus");
  a_oe_not_read: assert property (io_data_bus_oe |-> io_read_strobe_n) else $error("bus driven on read");
  // Timing of the bus phase against the select; start waits for a tick
  a_ext_strobe: assert property ($fell(selects.extended_area_select_n) |-> ##[1:20] strobe_any)
    else $error("extended select without strobe");
  a_sio_strobe: assert property ($fell(selects.simple_io_select_first_n) |-> ##[1:20] strobe_any)
    else $error("simple select without strobe");
  a_grant_done: assert property (!io_request_n && !io_grant_n |-> ##[1:6] req_done)
    else $error("grant did not end cycle");
  a_widen_pc: assert property (widen_ctl != widen_idle |-> selects.module_space_select_n && io_request_n)
    else $error("widening outside PC cycle");
endmodule // io_decode_checker

bind io_space_chip_select_decode io_decode_checker chk (.clk_sys(clk_sys), .rst(rst), .req_done(req_done),
  .req_internal(req_internal), .io_grant_n(io_grant_n), .io_request_n(io_request_n),
  .io_read_strobe_n(io_read_strobe_n), .io_write_strobe_n(io_write_strobe_n),
  .io_data_bus_oe(io_data_bus_oe), .selects(selects), .widen_ctl(widen_ctl));

// file: bench/io_periph_model.sv
// Behavioural peripheral on the far side of the I/O bus
`timescale 1ns/1ps
module io_periph_model (
  input wire logic clk_sys, // System clock
  input wire logic slow, // Answer slowly when high
  input wire logic [15:0] rd_value, // Data returned on reads
  input wire logic io_read_strobe_n, // Read strobe
  input wire logic io_request_n, // Handshake request
  input wire logic io_read_not_write, // Direction
  output logic io_ready, // Proceed when high
  output logic io_grant_n, // Grant, low
  output logic [15:0] io_data_bus_in // Bus level
);
  int busy_cnt = 0;
  initial begin
    io_ready = 1'b1;
    io_grant_n = 1'b1;
    io_data_bus_in = 16'h0;
  end
  // Cycle age drives both stretch and grant delay
  always @(posedge clk_sys) begin
    busy_cnt <= (io_read_strobe_n && io_request_n) ? 0 : busy_cnt + 1;
    io_ready <= !(slow && !io_read_strobe_n && busy_cnt < 40);
    io_grant_n <= !(!io_request_n && busy_cnt >= (slow ? 20 : 2));
    // Released bus toggles so a stale value can never pass
    if (!io_read_strobe_n || (!io_request_n && io_read_not_write)) begin
      io_data_bus_in <= rd_value;
    end else begin
      io_data_bus_in <= ~io_data_bus_in;
    end
  end
endmodule // io_periph_model

// file: bench/tb_top.sv
// Self-checking bench for the I/O chip-select decoder
`timescale 1ns/1ps
module tb_top;
  import io_decode_pkg::*;
  logic clk_sys = 0, rst = 1, req_valid = 0, req_write = 0, narrow_decode_input = 0, slow = 0;
  logic [31:0] req_addr = '0, req_wdata = '0, req_rdata;
  logic req_done, req_internal, io_ready, io_grant_n, io_request_n, io_read_strobe_n, io_write_strobe_n;
  logic io_read_not_write, io_data_bus_oe, wid, oe_seen, bus_bad, int_seen;
  logic [15:0] io_data_bus_in, io_data_bus_out;
  logic [8:0] act;
  logic [2:0] strb;
  select_bus_type selects;
  widen_ctl_type widen_ctl;
  int lows, error_cnt = 0, check_count = 0;
  localparam logic [15:0] rd_value = 16'hc35a;
  always #4 clk_sys = ~clk_sys;
  io_space_chip_select_decode uut (.clk_sys(clk_sys), .rst(rst), .req_valid(req_valid), .req_addr(req_addr),
    .req_write(req_write), .req_wdata(req_wdata), .req_done(req_done), .req_rdata(req_rdata),
    .req_internal(req_internal), .narrow_decode_input(narrow_decode_input), .io_ready(io_ready),
    .io_grant_n(io_grant_n), .io_request_n(io_request_n), .io_read_strobe_n(io_read_strobe_n),
    .io_write_strobe_n(io_write_strobe_n), .io_read_not_write(io_read_not_write),
    .io_data_bus_in(io_data_bus_in), .io_data_bus_out(io_data_bus_out), .io_data_bus_oe(io_data_bus_oe),
    .selects(selects), .widen_ctl(widen_ctl));
  io_periph_model periph (.clk_sys(clk_sys), .slow(slow), .rd_value(rd_value),
    .io_read_strobe_n(io_read_strobe_n), .io_request_n(io_request_n), .io_read_not_write(io_read_not_write),
    .io_ready(io_ready), .io_grant_n(io_grant_n), .io_data_bus_in(io_data_bus_in));
  // ----
  // Shared tasks
  // ----
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // One access at a falling edge; gather what the bus showed until done
  task automatic run(input logic [31:0] a, input logic w, input logic [8:0] m, input logic [2:0] s, input logic i);
    int n;
    n = 0;
    act = '0; strb = '0; lows = 0; wid = 0; oe_seen = 0; bus_bad = 0;
    req_addr = a; req_write = w; req_valid = 1;
    @(negedge clk_sys);
    req_valid = 0;
    while (req_done !== 1'b1 && n < 400) begin
      act |= selects ^ selects_idle;
      strb |= {~io_read_strobe_n, ~io_write_strobe_n, ~io_request_n};
      lows += int'(!io_read_strobe_n || !io_write_strobe_n);
      wid |= (widen_ctl != widen_idle);
      oe_seen |= io_data_bus_oe;
      bus_bad |= io_data_bus_oe && (io_data_bus_out !== req_wdata[31:16]);
      @(negedge clk_sys);
      n++;
    end
    int_seen = req_internal;
    if (n >= 400) begin
      error_cnt++;
      complete_run();
    end
    @(negedge clk_sys);
    check("selects", 32'(act), 32'(m));
    check("strobes", 32'(strb), 32'(s));
    check("idle", 32'(selects), 32'(selects_idle));
    if (i !== 1'bx) check("internal", 32'(int_seen), 32'(i));
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_pc();
    logic [31:0] a [5] = '{32'h0301_0000, 32'h0301_2000, 32'h0302_a000, 32'h0302_b000, 32'h0302_b800};
    logic [8:0] m [5] = '{9'h080, 9'h040, 9'h060, 9'h008, 9'h010};
    for (int k = 0; k < 13; k++) begin
      if (k < 5) run(a[k], 1'b0, m[k], 3'b100, 1'b0);
      else run(32'h0800_0000 + (32'(k - 5) << 24) + 32'h2, 1'b0, 9'h001, 3'b100, 1'b0);
      check("wide", 32'(wid), 32'h1);
      check("rdata", req_rdata, {16'h0, rd_value});
    end
  endtask
  task automatic t_module();
    run(32'h0300_0000, 1'b0, 9'h100, 3'b001, 1'b0);
    check("rdata", req_rdata, {16'h0, rd_value});
    req_wdata = 32'h6b21_0000;
    slow = 1;
    run(32'h0303_fffe, 1'b1, 9'h100, 3'b001, 1'b0);
    slow = 0;
    check("wide", 32'(wid), 32'h0);
  endtask
  task automatic t_internal();
    logic [31:0] a [5] = '{32'h0320_0000, 32'h0340_0010, 32'h0302_c000, 32'h0304_0000, 32'h0350_0000};
    for (int k = 0; k < 5; k++) run(a[k], k[0], 9'h000, 3'b000, k < 2);
  endtask
  task automatic t_simple();
    logic [31:0] a [4] = '{32'h0321_0000, 32'h0329_0000, 32'h0331_0000, 32'h0339_0000};
    int len [4] = '{7, 6, 5, 5};
    for (int k = 0; k < 4; k++) begin
      run(a[k], 1'b0, 9'h004, 3'b100, 1'b0);
      check("length", 32'(lows >= (len[k] + 1) * 15 - 2 && lows <= (len[k] + 1) * 15 + 2), 32'h1);
    end
    run(32'h0324_fffe, 1'b0, 9'h006, 3'b100, 1'b0);
  endtask
  task automatic t_write();
    req_wdata = 32'h9e61_1234;
    run(32'h0302_b800, 1'b1, 9'h010, 3'b010, 1'b0);
    check("drive", 32'({oe_seen, bus_bad}), 32'h2);
    run(32'h033c_0000, 1'b1, 9'h006, 3'b010, 1'b0);
    check("drive", 32'({oe_seen, bus_bad}), 32'h2);
  endtask
  task automatic t_stretch();
    slow = 1;
    run(32'h0301_0000, 1'b0, 9'h080, 3'b100, 1'b0);
    slow = 0;
    check("stretch", 32'(lows >= 40), 32'h1);
  endtask
  task automatic t_narrow();
    narrow_decode_input = 1;
    repeat (4) @(negedge clk_sys);
    run(32'h0300_4000, 1'b0, 9'h000, 3'b000, 1'b0);
    run(32'h0303_3ffe, 1'b0, 9'h100, 3'b001, 1'b0);
    run(32'h0324_4000, 1'b0, 9'h004, 3'b100, 1'b0);
    run(32'h0900_0000, 1'b0, 9'h000, 3'b100, 1'b0);
    narrow_decode_input = 0;
    repeat (4) @(negedge clk_sys);
  endtask
  initial begin
    repeat (6) @(negedge clk_sys);
    rst = 0;
    t_pc();
    t_module();
    t_internal();
    t_simple();
    t_write();
    t_stretch();
    t_narrow();
    t_pc();
    complete_run();
  end
endmodule // tb_top
